// ===== shared/chpwr_pkg.sv
package chpwr_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] OFS_INPUT_ENABLE = 8'h73;
	localparam logic [7:0] OFS_SLOT_ENABLE = 8'h74;
	localparam logic [7:0] OFS_POWER_CFG = 8'h75;
	localparam logic [7:0] OFS_POWER_STATUS = 8'h76;
	localparam logic [7:0] OFS_MODE_STATUS = 8'h77;

	localparam logic [7:0] RST_INPUT_ENABLE = 8'hF0;
	localparam logic [7:0] RST_SLOT_ENABLE = 8'h00;
	localparam logic [7:0] RST_POWER_CFG = 8'h00;
	localparam logic [7:0] RST_POWER_STATUS = 8'h00;
	localparam logic [7:0] RST_READ_DATA = 8'h00;

	// ************************************************************
	// Fields
	// ************************************************************
	localparam int BIT_BIAS = 7;
	localparam int BIT_CONV = 6;
	localparam int BIT_PLL = 5;
	localparam int BIT_DYN = 4;
	localparam int GROUP_LSB = 2;
	localparam int MODE_LSB = 5;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hFC;
	localparam int NUM_CH = 8;
	localparam int NUM_ANALOG_CH = 4;

	localparam logic [2:0] MODE_SLEEP = 3'h4;
	localparam logic [2:0] MODE_IDLE = 3'h6;
	localparam logic [2:0] MODE_ACTIVE = 3'h7;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic bias_on;
		logic conv_on;
		logic pll_on;
		logic dyn_en;
		logic [1:0] group;
		logic [1:0] rsvd;
	} power_cfg_s;

	typedef struct packed {
		logic on;
	} cell_state_s;

endpackage : chpwr_pkg

// ===== src/power_channel_cell.sv
module power_channel_cell (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic want,
	input wire logic allow,
	output logic power_state
);
	import chpwr_pkg::*;

	cell_state_s s_q;
	cell_state_s s_d;

	// ************************************************************
	// Power state of one channel
	// ************************************************************
	always_comb begin
		s_d = s_q;
		if (allow) begin
			s_d.on = want;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign power_state = s_q.on;

	property p_hold_unless_allowed;
		@(posedge clk) disable iff (!rst_n)
		!allow |=> $stable(power_state);
	endproperty
	a_hold_unless_allowed: assert property (p_hold_unless_allowed)
		else $error("channel power changed without permission");

endmodule : power_channel_cell

// ===== src/channel_power_slot_control.sv
module channel_power_slot_control (
	input wire logic clk,
	input wire logic rst_n,
	input chpwr_pkg::reg_req_s req,
	input wire logic sleep_mode,
	input wire logic pdm_inputs_on,
	output logic [7:0] rdata,
	output logic [7:0] slot_drive_enable,
	output logic bias_power_on,
	output logic converter_power_on,
	output logic pll_power_on,
	output logic [7:0] chan_power_state,
	output logic [2:0] device_mode_state
);
	import chpwr_pkg::*;

	typedef struct packed {
		logic [7:0] in_en;
		logic [7:0] slot_en;
		power_cfg_s cfg;
		logic [7:0] rdata;
		logic [2:0] mode;
	} ctrl_state_s;

	ctrl_state_s s_q;
	ctrl_state_s s_d;
	logic [NUM_CH-1:0] want;
	logic [NUM_CH-1:0] allow;
	logic [NUM_CH-1:0] in_group;
	logic any_on;
	logic global_down;
	logic [3:0] group_count;

	// ************************************************************
	// Channel power decisions
	// ************************************************************
	// Channel index 0 is channel 1, which sits at register bit 7
	assign any_on = |chan_power_state;
	assign global_down = !s_q.cfg.conv_on || sleep_mode;
	assign group_count = {1'b0, s_q.cfg.group, 1'b0} + 4'h2;

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			in_group[i] = (4'(i) < group_count);
			want[i] = s_q.cfg.conv_on && !sleep_mode && s_q.in_en[NUM_CH-1-i];
			if (i >= NUM_ANALOG_CH) begin
				want[i] = want[i] && pdm_inputs_on;
			end
			if (s_q.cfg.dyn_en && !in_group[i]) begin
				want[i] = 1'b0;
			end
			// Static mode only lets channels move together, from all-off or while converters are off or in sleep
			allow[i] = global_down || !any_on || (s_q.cfg.dyn_en && in_group[i]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_cell
			power_channel_cell u_cell (
				.clk(clk),
				.rst_n(rst_n),
				.want(want[g]),
				.allow(allow[g]),
				.power_state(chan_power_state[NUM_CH-1-g])
			);
		end
	endgenerate

	// ************************************************************
	// Register file
	// ************************************************************
	always_comb begin
		s_d = s_q;
		if (req.wr) begin
			unique case (req.addr)
				OFS_INPUT_ENABLE: s_d.in_en = req.wdata;
				OFS_SLOT_ENABLE: s_d.slot_en = req.wdata;
				OFS_POWER_CFG: s_d.cfg = power_cfg_s'(req.wdata & CFG_WRITE_MASK);
				default: s_d = s_q;
			endcase
		end
		if (req.rd) begin
			unique case (req.addr)
				OFS_INPUT_ENABLE: s_d.rdata = s_q.in_en;
				OFS_SLOT_ENABLE: s_d.rdata = s_q.slot_en;
				OFS_POWER_CFG: s_d.rdata = s_q.cfg;
				OFS_POWER_STATUS: s_d.rdata = chan_power_state;
				OFS_MODE_STATUS: s_d.rdata = {s_q.mode, 5'h00};
				default: s_d.rdata = 8'h00;
			endcase
		end
		// Mode trails channel state by one cycle, as the status does
		if (sleep_mode) begin
			s_d.mode = MODE_SLEEP;
		end else if (any_on) begin
			s_d.mode = MODE_ACTIVE;
		end else begin
			s_d.mode = MODE_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q.in_en <= RST_INPUT_ENABLE;
			s_q.slot_en <= RST_SLOT_ENABLE;
			s_q.cfg <= power_cfg_s'(RST_POWER_CFG);
			s_q.rdata <= RST_READ_DATA;
			s_q.mode <= MODE_SLEEP;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// A cleared slot enable leaves the serial slot undriven
	assign slot_drive_enable = s_q.slot_en;
	assign bias_power_on = s_q.cfg.bias_on;
	assign converter_power_on = s_q.cfg.conv_on;
	assign pll_power_on = s_q.cfg.pll_on;
	assign device_mode_state = s_q.mode;
	assign rdata = s_q.rdata;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_slot_write;
		@(posedge clk) disable iff (!rst_n)
		req.wr && req.addr == OFS_SLOT_ENABLE
		|=> slot_drive_enable == $past(req.wdata);
	endproperty
	a_slot_write: assert property (p_slot_write)
		else $error("slot enables did not take the written value");

	property p_reset_values;
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> slot_drive_enable == RST_SLOT_ENABLE
			&& chan_power_state == RST_POWER_STATUS
			&& s_q.in_en == RST_INPUT_ENABLE
			&& device_mode_state == MODE_SLEEP;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("wrong value after reset release");

	property p_bias_write;
		@(posedge clk) disable iff (!rst_n)
		req.wr && req.addr == OFS_POWER_CFG
		|=> bias_power_on == $past(req.wdata[BIT_BIAS])
			&& pll_power_on == $past(req.wdata[BIT_PLL]);
	endproperty
	a_bias_write: assert property (p_bias_write)
		else $error("bias or pll power does not follow its bit");

	property p_conv_off;
		@(posedge clk) disable iff (!rst_n)
		!converter_power_on |=> chan_power_state == 8'h00;
	endproperty
	a_conv_off: assert property (p_conv_off)
		else $error("channel powered while converters are off");

	property p_pll_follow;
		@(posedge clk) disable iff (!rst_n)
		$changed(pll_power_on) |-> $past(req.wr) && $past(req.addr) == OFS_POWER_CFG;
	endproperty
	a_pll_follow: assert property (p_pll_follow)
		else $error("pll power changed without a write");

	property p_static_hold;
		@(posedge clk) disable iff (!rst_n)
		!s_q.cfg.dyn_en && converter_power_on && !sleep_mode && any_on
		|=> $stable(chan_power_state);
	endproperty
	a_static_hold: assert property (p_static_hold)
		else $error("channel switched while recording in static mode");

	property p_dynamic_ch1;
		@(posedge clk) disable iff (!rst_n)
		s_q.cfg.dyn_en && converter_power_on && !sleep_mode
		|=> chan_power_state[7] == $past(s_q.in_en[7]);
	endproperty
	a_dynamic_ch1: assert property (p_dynamic_ch1)
		else $error("channel 1 did not follow its enable in dynamic mode");

	property p_group_limit;
		@(posedge clk) disable iff (!rst_n)
		s_q.cfg.dyn_en && s_q.cfg.group == 2'h0
		|=> !$rose(chan_power_state[5]);
	endproperty
	a_group_limit: assert property (p_group_limit)
		else $error("channel 3 powered outside the dynamic group");

	property p_reserved_zero;
		@(posedge clk) disable iff (!rst_n)
		s_q.cfg.rsvd == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved power bits not zero");

	property p_pdm_only;
		@(posedge clk) disable iff (!rst_n)
		!pdm_inputs_on |=> (chan_power_state[3:0] & ~$past(chan_power_state[3:0])) == 4'h0;
	endproperty
	a_pdm_only: assert property (p_pdm_only)
		else $error("pdm-only channel powered without pdm inputs");

	property p_mode_active;
		@(posedge clk) disable iff (!rst_n)
		!sleep_mode && any_on |=> device_mode_state == MODE_ACTIVE;
	endproperty
	a_mode_active: assert property (p_mode_active)
		else $error("mode not active with a channel on");

	property p_status_write;
		@(posedge clk) disable iff (!rst_n)
		req.wr && req.addr == OFS_POWER_STATUS && global_down && !any_on
		|=> chan_power_state == 8'h00;
	endproperty
	a_status_write: assert property (p_status_write)
		else $error("status write changed channel power");

	// The status offset has no storage behind it, so a write there must leave every register alone
	property p_status_ignored;
		@(posedge clk) disable iff (!rst_n)
		req.wr && req.addr == OFS_POWER_STATUS
		|=> s_q.in_en == $past(s_q.in_en) && s_q.cfg == $past(s_q.cfg)
			&& slot_drive_enable == $past(slot_drive_enable);
	endproperty
	a_status_ignored: assert property (p_status_ignored)
		else $error("status write changed a register");

endmodule : channel_power_slot_control

// ===== tb/chpwr_host.sv
module chpwr_host
	import chpwr_pkg::*;
(
	input wire logic clk,
	output chpwr_pkg::reg_req_s req,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********************************
	// Control port master
	// ********************************
	initial begin
		req = '0;
	end

	// One single-byte write; strobe stands exactly one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask : wr

	// Read data is taken once the strobe edge's updates have landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		d = rdata;
	endtask : rd
endmodule : chpwr_host

// ===== tb/channel_power_slot_control_tb.sv
module channel_power_slot_control_tb import chpwr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sleep_mode = 1'b0;
	logic pdm_inputs_on = 1'b0;
	reg_req_s req;
	logic [7:0] rdata, slot_drive_enable, chan_power_state;
	logic bias_power_on, converter_power_on, pll_power_on;
	logic [2:0] device_mode_state;
	int num_errors = 0;
	int samples_checked = 0;

	channel_power_slot_control dut (.clk(clk), .rst_n(rst_n), .req(req),
		.sleep_mode(sleep_mode), .pdm_inputs_on(pdm_inputs_on), .rdata(rdata),
		.slot_drive_enable(slot_drive_enable), .bias_power_on(bias_power_on),
		.converter_power_on(converter_power_on), .pll_power_on(pll_power_on),
		.chan_power_state(chan_power_state), .device_mode_state(device_mode_state));
	chpwr_host host (.clk(clk), .req(req), .rdata(rdata));

	// ********************************
	// Helpers
	// ********************************
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask : rchk

	// Status trails its cause by one edge and mode by two; three leaves margin
	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	function automatic logic [7:0] pwr();
		return {bias_power_on, converter_power_on, pll_power_on, 5'h00};
	endfunction : pwr

	// ********************************
	// Scenarios
	// ********************************
	task t_reset;
		#1;
		chk("mode", 8'h04, {5'h00, device_mode_state});
		@(posedge clk);
		#1;
		chk("slots", 8'h00, slot_drive_enable);
		chk("power", 8'h00, pwr());
		chk("status", 8'h00, chan_power_state);
		rchk(8'h74, 8'h00);
		rchk(8'h75, 8'h00);
		rchk(8'h76, 8'h00);
		rchk(8'h73, 8'hF0);
		rchk(8'h77, 8'hC0);
		rchk(8'h10, 8'h00);
	endtask : t_reset

	task t_slots;
		host.wr(8'h74, 8'h81);
		#1;
		chk("slots", 8'h81, slot_drive_enable);
		rchk(8'h74, 8'h81);
	endtask : t_slots

	task t_power;
		host.wr(8'h75, 8'hFF);
		settle;
		chk("power", 8'hE0, pwr());
		chk("status", 8'hF0, chan_power_state);
		chk("mode", 8'h07, {5'h00, device_mode_state});
		rchk(8'h75, 8'hFC);
	endtask : t_power

	task t_pdm;
		host.wr(8'h73, 8'hF8);
		settle;
		chk("status", 8'hF0, chan_power_state);
		@(posedge clk) pdm_inputs_on <= 1'b1;
		settle;
		chk("status", 8'hF8, chan_power_state);
	endtask : t_pdm

	task t_static;
		host.wr(8'h75, 8'hC0);
		host.wr(8'h73, 8'h78);
		settle;
		chk("status", 8'hF8, chan_power_state);
		host.wr(8'h75, 8'h80);
		settle;
		chk("status", 8'h00, chan_power_state);
		chk("mode", 8'h06, {5'h00, device_mode_state});
		host.wr(8'h75, 8'hC0);
		settle;
		chk("status", 8'h78, chan_power_state);
		host.wr(8'h76, 8'hFF);
		rchk(8'h76, 8'h78);
		rchk(8'h77, 8'hE0);
	endtask : t_static

	task t_group;
		host.wr(8'h75, 8'hD0);
		host.wr(8'h73, 8'hF8);
		settle;
		chk("group", 8'hC0, {chan_power_state[7:6], 6'h00});
		host.wr(8'h73, 8'h78);
		settle;
		chk("group", 8'h40, {chan_power_state[7:6], 6'h00});
	endtask : t_group

	task t_sleep;
		@(posedge clk) sleep_mode <= 1'b1;
		settle;
		chk("status", 8'h00, chan_power_state);
		chk("mode", 8'h04, {5'h00, device_mode_state});
	endtask : t_sleep

	task tally_and_finish;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	// ********************************
	// Run
	// ********************************
	initial begin
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_slots;
		t_power;
		t_pdm;
		t_static;
		t_group;
		t_sleep;
		tally_and_finish;
	end

	// Whole run needs under a hundred cycles
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
endmodule : channel_power_slot_control_tb
